// ---- verilog/i2c_raw_status.v ----
// Raw interrupt status for receive FIFO and slave read request, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "i2c_raw_status_consts.vh"

module i2c_raw_status
#(
	parameter CNT_W   = 4,
	parameter RX_DEPTH = 8
)
(
	input  wire             ref_clk,
	input  wire             rst,
	// AXI4-Lite write address
	input  wire [7:0]       s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output reg              s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output reg              s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]       s_axi_araddr,
	input  wire             s_axi_arvalid,
	output reg              s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready,
	// Receive FIFO side
	input  wire [CNT_W:0]   rx_count,
	input  wire             rx_fifo_read,
	// Transmit FIFO side
	input  wire             tx_fifo_write,
	input  wire             tx_empty,
	output reg              tx_flush,
	// Protocol engine side
	input  wire             slave_read_addressed,
	input  wire             slave_read_active,
	// Interrupt
	output wire             irq
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [7:0]       aw_addr;
	reg              aw_held;
	reg  [31:0]      w_data;
	reg  [3:0]       w_strb;
	reg              w_held;
	reg  [7:0]       rx_threshold_register;
	reg  [31:0]      irq_mask;
	reg              rx_nearly_full_flag;
	reg              slave_read_empty_flag;
	reg              next_read_empty;
	reg  [31:0]      rd_value;
	reg              rd_ok;
	reg              wr_ok;
	reg  [31:0]      prev_raw;
	wire             rx_full_flag;
	wire             slave_read_request_flag;
	wire             do_write;
	wire             clear_reg_write;
	wire             irq_clear_write;
	wire [31:0]      raw_interrupt_status;
	wire [31:0]      irq_events;
	wire [31:0]      irq_clear;
	wire [31:0]      irq_status;
	wire             rx_is_full;
	wire             request_clear;

	assign do_write  = aw_held & w_held & ~s_axi_bvalid;
	assign clear_reg_write = do_write & (aw_addr == `OFS_CLEAR);
	assign irq_clear_write = do_write & (aw_addr == `OFS_IRQ_STATUS);

	// ----------------------------------------
	// Receive FIFO flags
	// ----------------------------------------
	assign rx_is_full = (rx_count >= RX_DEPTH[CNT_W:0]);

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rx_nearly_full_flag <= `RST_FLAG;
		else
			rx_nearly_full_flag <= ({{(8-CNT_W-1){1'b0}}, rx_count} >= rx_threshold_register);
	end

	flag_cell u_rx_full
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.set     (rx_is_full & ~rx_fifo_read),
		.clr     (rx_fifo_read),
		.q       (rx_full_flag)
	);

	// ----------------------------------------
	// Slave read request
	// ----------------------------------------
	// software clears
	assign request_clear = tx_fifo_write | (clear_reg_write & w_data[`BIT_SLV_READ_REQ]);

	flag_cell u_slv_req
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.set     (slave_read_addressed),
		.clr     (request_clear),
		.q       (slave_read_request_flag)
	);

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			tx_flush <= 1'b0;
		else
			tx_flush <= slave_read_addressed;
	end

	// the CPU refills after the flush; a fill in the flush cycle is lost
	always @*
	begin
		next_read_empty = slave_read_active & tx_empty & ~tx_fifo_write;
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			slave_read_empty_flag <= `RST_FLAG;
		else
			slave_read_empty_flag <= next_read_empty;
	end

	// ----------------------------------------
	// Raw status word
	// ----------------------------------------
	// reserved bits zero
	assign raw_interrupt_status = {14'h0000,
				       slave_read_empty_flag,
				       slave_read_request_flag,
				       9'h000,
				       rx_full_flag,
				       rx_nearly_full_flag,
				       5'h00};

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			prev_raw <= 32'h00000000;
		else
			prev_raw <= raw_interrupt_status;
	end

	// Rising edges only, so a standing level does not refire after a clear
	assign irq_events = raw_interrupt_status & ~prev_raw;
	assign irq_clear  = irq_clear_write ? w_data : 32'h00000000;

	sticky_irq #(.W(32)) u_irq
	(
		.ref_clk  (ref_clk),
		.rst      (rst),
		.event_in (irq_events),
		.clear_in (irq_clear),
		.mask     (irq_mask),
		.status   (irq_status),
		.irq      (irq)
	);

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	always @*
	begin
		case (aw_addr)
			`OFS_RAW_STATUS:   wr_ok = 1'b1;
			`OFS_CLEAR:        wr_ok = 1'b1;
			`OFS_RX_THRESHOLD: wr_ok = 1'b1;
			`OFS_IRQ_STATUS:   wr_ok = 1'b1;
			`OFS_IRQ_MASK:     wr_ok = 1'b1;
			default:           wr_ok = 1'b0;
		endcase
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_addr       <= 8'h00;
			aw_held       <= 1'b0;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			w_held        <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr       <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Writable registers; raw status ignores writes
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_threshold_register <= `RST_RX_THRESHOLD;
			irq_mask              <= `RST_IRQ_MASK;
		end
		else if (do_write)
		begin
			if (aw_addr == `OFS_RX_THRESHOLD && w_strb[0])
				rx_threshold_register <= w_data[7:0];
			if (aw_addr == `OFS_IRQ_MASK)
			begin
				if (w_strb[0])
					irq_mask[7:0] <= w_data[7:0];
				if (w_strb[1])
					irq_mask[15:8] <= w_data[15:8];
				if (w_strb[2])
					irq_mask[23:16] <= w_data[23:16];
				if (w_strb[3])
					irq_mask[31:24] <= w_data[31:24];
			end
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always @*
	begin
		rd_ok    = 1'b1;
		rd_value = 32'h00000000;
		case (s_axi_araddr)
			`OFS_RAW_STATUS:   rd_value = raw_interrupt_status;
			`OFS_CLEAR:        rd_value = 32'h00000000;
			`OFS_RX_THRESHOLD: rd_value = {24'h000000, rx_threshold_register};
			`OFS_IRQ_STATUS:   rd_value = irq_status;
			`OFS_IRQ_MASK:     rd_value = irq_mask;
			default:           rd_ok = 1'b0;
		endcase
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_value;
				s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // i2c_raw_status

`default_nettype wire

// ---- verilog/i2c_raw_status_consts.vh ----
// Constants for the I2C raw interrupt status block
//
// Contract
// - Receive-nearly-full bit 5 sets while receive count reaches programmed threshold.
// - Receive-nearly-full bit clears itself once count falls below threshold.
// - Receive-full bit 6 sets when the receive FIFO becomes full.
// - Receive-full bit clears itself when data are read from receive FIFO.
// - Slave-read-request bit 16 sets when a master addresses us for reading.
// - On slave-read-request assertion the transmit FIFO is flushed completely.
// - Slave-read-request bit clears itself when software writes the transmit FIFO.
// - Transmit FIFO running empty during a slave read sets slave-read-empty.
// - Writing one to clear register bit 16 also clears slave-read-request.
// - Slave-read-empty bit 17 follows read-in-progress and empty; clears on write/end.
`ifndef I2C_RAW_STATUS_CONSTS_VH
`define I2C_RAW_STATUS_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_RAW_STATUS     8'h00
`define OFS_CLEAR          8'h04
`define OFS_RX_THRESHOLD   8'h08
`define OFS_IRQ_STATUS     8'h0c
`define OFS_IRQ_MASK       8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_RX_NEARLY_FULL 5
`define BIT_RX_FULL        6
`define BIT_SLV_READ_REQ   16
`define BIT_SLV_READ_EMPTY 17

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_RX_THRESHOLD   8'h01
`define RST_IRQ_MASK       32'h00000000
`define RST_FLAG           1'b0

// ----------------------------------------
// Bus response codes
// ----------------------------------------
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// ---- verilog/flag_cell.v ----
// Self-clearing status flag with set priority
`timescale 1ns/1ps
`default_nettype none

module flag_cell
(
	input  wire ref_clk,
	input  wire rst,
	input  wire set,
	input  wire clr,
	output reg  q
);

	// Set wins so an event meeting a clear is never lost
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			q <= 1'b0;
		else if (set)
			q <= 1'b1;
		else if (clr)
			q <= 1'b0;
	end

endmodule // flag_cell

`default_nettype wire

// ---- verilog/sticky_irq.v ----
// Sticky interrupt status with write-one-to-clear and masked output
`timescale 1ns/1ps
`default_nettype none

module sticky_irq
#(
	parameter W = 32
)
(
	input  wire         ref_clk,
	input  wire         rst,
	input  wire [W-1:0] event_in,
	input  wire [W-1:0] clear_in,
	input  wire [W-1:0] mask,
	output reg  [W-1:0] status,
	output reg          irq
);

	wire [W-1:0] next_status;

	// New events override a simultaneous clear
	assign next_status = (status & ~clear_in) | event_in;

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			status <= {W{1'b0}};
			irq    <= 1'b0;
		end
		else
		begin
			status <= next_status;
			irq    <= |(next_status & mask);
		end
	end

endmodule // sticky_irq

`default_nettype wire

// ---- sim/i2c_raw_status_properties.sv ----
// Checker for the transmit flush pulse, reserved status bits and bus handshakes of the raw status block
`timescale 1ns/1ps
`default_nettype none
`include "i2c_raw_status_consts.vh"
module i2c_raw_status_checker
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        slave_read_addressed,
	input wire logic        tx_flush,
	input wire logic        irq,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready
);
	logic [7:0] read_addr;
	// Address of the read whose data stand on the bus
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			read_addr <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			read_addr <= s_axi_araddr;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_flush_follows: assert property (slave_read_addressed |=> tx_flush)
		else $error("flush missing after read request");
	a_flush_cause: assert property (tx_flush |-> $past(slave_read_addressed))
		else $error("flush without read request");
	a_flush_once: assert property (tx_flush && !slave_read_addressed |=> !tx_flush)
		else $error("flush pulse too long");
	a_reserved_zero: assert property (s_axi_rvalid && read_addr == `OFS_RAW_STATUS
		|-> (s_axi_rdata & 32'h0000ff80) == 32'h00000000)
		else $error("reserved status bits not zero");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing after address taken");
	a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data kept after taken");
	a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response kept after taken");
	c_request: cover property (slave_read_addressed);
	c_flush: cover property (tx_flush ##1 !tx_flush);
	c_irq: cover property ($rose(irq));
endmodule // i2c_raw_status_checker
bind i2c_raw_status i2c_raw_status_checker chk_i
	(.ref_clk(ref_clk), .rst(rst), .slave_read_addressed(slave_read_addressed),
	.tx_flush(tx_flush), .irq(irq), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// ---- sim/i2c_master_model.sv ----
// External bus master that addresses the block for reads
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
	input  wire logic ref_clk,
	output var  logic slave_read_addressed,
	output var  logic slave_read_active
);
	// ----------------------------------------
	// Read transfers
	// ----------------------------------------
	initial
	begin
		slave_read_addressed = 1'b0;
		slave_read_active = 1'b0;
	end
	// Address phase lasts one cycle; the transfer stays open until stopped
	task start_read;
		@(posedge ref_clk);
		slave_read_addressed <= 1'b1;
		slave_read_active <= 1'b1;
		@(posedge ref_clk);
		slave_read_addressed <= 1'b0;
	endtask
	task stop_read;
		@(posedge ref_clk);
		slave_read_active <= 1'b0;
	endtask
endmodule // i2c_master_model
`default_nettype wire

// ---- sim/tb_i2c_raw_status.sv ----
// Self-checking testbench for the raw status block
`timescale 1ns/1ps
`default_nettype none
`include "i2c_raw_status_consts.vh"
module tb_i2c_raw_status;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [31:0] NF = 32'h1 << `BIT_RX_NEARLY_FULL;
	localparam logic [31:0] F = 32'h1 << `BIT_RX_FULL;
	localparam logic [31:0] Q = 32'h1 << `BIT_SLV_READ_REQ;
	localparam logic [31:0] E = 32'h1 << `BIT_SLV_READ_EMPTY;
	logic        ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata;
	logic [4:0]  rx_count;
	logic        rx_fifo_read, tx_fifo_write, tx_empty;
	wire logic   awready, wready, bvalid, arready, rvalid, tx_flush, irq, addressed, active;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          errors, compares, flushes, cycles;
	i2c_raw_status dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_count(rx_count), .rx_fifo_read(rx_fifo_read),
		.tx_fifo_write(tx_fifo_write), .tx_empty(tx_empty), .tx_flush(tx_flush),
		.slave_read_addressed(addressed), .slave_read_active(active), .irq(irq));
	i2c_master_model m (.ref_clk(ref_clk), .slave_read_addressed(addressed),
		.slave_read_active(active));
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Hang guard well above the hundred or so cycles the run needs
	always @(posedge ref_clk)
	begin
		cycles++;
		if (tx_flush === 1'b1)
			flushes++;
		if (cycles == 5000)
		begin
			errors++;
			results();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
			begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (awvalid || wvalid);
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, r});
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, d);
		chk({30'h0, rresp}, {30'h0, r});
	endtask
	task results;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		{rst, tx_empty} = 2'b11;
		{awvalid, wvalid, bready, arvalid, rready, rx_fifo_read, tx_fifo_write} = 7'h00;
		{awaddr, araddr, wdata, rx_count} = 53'h0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`OFS_RAW_STATUS, 32'h0, `RESP_OKAY);
		wr(`OFS_RX_THRESHOLD, 32'h3, `RESP_OKAY);
		rx_count <= 5'h03;
		rd(`OFS_RAW_STATUS, NF, `RESP_OKAY);
		rx_count <= 5'h02;
		rd(`OFS_RAW_STATUS, 32'h0, `RESP_OKAY);
		rx_count <= 5'h08;
		rd(`OFS_RAW_STATUS, NF | F, `RESP_OKAY);
		rx_fifo_read <= 1'b1;
		rx_count <= 5'h07;
		@(posedge ref_clk);
		rx_fifo_read <= 1'b0;
		rd(`OFS_RAW_STATUS, NF, `RESP_OKAY);
		rx_count <= 5'h00;
		$display("receive flag tests done");
		m.start_read();
		rd(`OFS_RAW_STATUS, Q | E, `RESP_OKAY);
		chk(flushes, 1);
		tx_fifo_write <= 1'b1;
		tx_empty <= 1'b0;
		@(posedge ref_clk);
		tx_fifo_write <= 1'b0;
		rd(`OFS_RAW_STATUS, 32'h0, `RESP_OKAY);
		tx_empty <= 1'b1;
		rd(`OFS_RAW_STATUS, E, `RESP_OKAY);
		m.stop_read();
		rd(`OFS_RAW_STATUS, 32'h0, `RESP_OKAY);
		m.start_read();
		wr(`OFS_CLEAR, Q, `RESP_OKAY);
		rd(`OFS_RAW_STATUS, E, `RESP_OKAY);
		m.stop_read();
		wr(`OFS_RAW_STATUS, 32'hffffffff, `RESP_OKAY);
		rd(`OFS_RAW_STATUS, 32'h0, `RESP_OKAY);
		rd(8'h20, 32'h0, `RESP_SLVERR);
		wr(8'h20, 32'h0, `RESP_SLVERR);
		$display("slave read tests done");
		wr(`OFS_IRQ_STATUS, 32'hffffffff, `RESP_OKAY);
		wr(`OFS_IRQ_MASK, Q, `RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		m.start_read();
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		rd(`OFS_IRQ_STATUS, Q | E, `RESP_OKAY);
		wr(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		wr(`OFS_IRQ_MASK, Q, `RESP_OKAY);
		wr(`OFS_IRQ_STATUS, Q, `RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		m.stop_read();
		$display("interrupt tests done");
		results();
	end
endmodule // tb_i2c_raw_status
`default_nettype wire
